// ===== design/gate_control_regs.vh
// Register map, field positions and reset values of the counter gate control block
`ifndef GATE_CONTROL_REGS_VH
`define GATE_CONTROL_REGS_VH

// Register bus widths
`define GC_ADDR_W             3
`define GC_DATA_W             8

// Register offsets
`define GC_OFF_GATE_CONTROL   3'h0
`define GC_OFF_COUNTER_CTRL   3'h1
`define GC_OFF_IRQ_STATUS     3'h2
`define GC_OFF_IRQ_CLEAR      3'h3
`define GC_OFF_IRQ_ENABLE     3'h4

// Fields of gate_control
`define GC_BIT_GATE_ENABLE    7
`define GC_BIT_GATE_POLARITY  6
`define GC_BIT_TOGGLE_MODE    5
`define GC_BIT_SINGLE_PULSE   4
`define GC_BIT_ACQUIRE_GO     3
`define GC_BIT_GATE_VALUE     2
`define GC_BIT_SOURCE_HI      1
`define GC_BIT_SOURCE_LO      0

// Fields of counter_ctrl
`define GC_BIT_COUNTER_ON     0
`define GC_BIT_COMP_SYNC      1

// Fields of the interrupt status, clear and enable registers
`define GC_IRQ_W              2
`define GC_IRQ_GATE_EVENT     0
`define GC_IRQ_ACQ_DONE       1

// Gate source codes
`define GC_SRC_PIN            2'h0
`define GC_SRC_PERIOD_MATCH   2'h1
`define GC_SRC_COMP_ONE       2'h2
`define GC_SRC_COMP_TWO       2'h3

// Reset values
`define GC_RST_GATE_CONTROL   8'h00
`define GC_RST_COUNTER_CTRL   2'h0
`define GC_RST_IRQ            2'h0

`endif

// ===== design/gate_sync.v
// Two-stage synchroniser for one level input
`timescale 1ns/100ps
module gate_sync (
   // Clock and reset
   input  wire clock,
   input  wire srst,
   // Level in and synchronised level out
   input  wire level_in,
   output wire level_out
);

   reg stage1_q;
   reg stage2_q;

   // The first stage feeds only the second stage, never any logic
   always @(posedge clock)
   begin
      if (srst)
      begin
         stage1_q <= 1'b0;
         stage2_q <= 1'b0;
      end
      else
      begin
         stage1_q <= level_in;
         stage2_q <= stage1_q;
      end
   end

   assign level_out = stage2_q;

endmodule

// ===== design/gate_pulse.v
// Toggle flip-flop and single-pulse acquisition stage of the gate path
`timescale 1ns/100ps
module gate_pulse (
   // Clock and reset
   input  wire clock,
   input  wire srst,
   // Gate after source selection and polarity
   input  wire gate_in,
   // Controls
   input  wire toggle_mode,
   input  wire single_pulse_mode,
   input  wire counter_on,
   input  wire acquire_go,
   // Processed gate and completion pulse
   output wire gate_out,
   output wire acquire_done
);

   reg  gate_prev_q;
   reg  toggle_q;
   reg  toggle_d;
   reg  stage_prev_q;
   reg  window_q;
   reg  window_d;
   wire gate_rise;
   wire stage;
   wire stage_rise;
   wire stage_fall;

   assign gate_rise = gate_in & ~gate_prev_q;

   // Toggle flip-flop: flips on each rising gate edge, cleared when idle
   always @*
   begin
      toggle_d = toggle_q;
      if (!toggle_mode || !counter_on)
         toggle_d = 1'b0;
      else if (gate_rise)
         toggle_d = ~toggle_q;
   end

   // With toggling on, one window spans a whole input period
   assign stage      = toggle_mode ? toggle_q : gate_in;
   assign stage_rise = stage & ~stage_prev_q;
   assign stage_fall = ~stage & stage_prev_q;

   // Window opens on the first leading edge after arming, closes on trailing
   always @*
   begin
      window_d = window_q;
      if (!single_pulse_mode || !acquire_go)
         window_d = 1'b0;
      else if (stage_rise)
         window_d = 1'b1;
      else if (stage_fall)
         window_d = 1'b0;
   end

   // A gate already high at arming time waits for a fresh edge
   assign gate_out = single_pulse_mode ?
                     (acquire_go & (window_q | stage_rise) & stage) : stage;
   assign acquire_done = single_pulse_mode & acquire_go & window_q & stage_fall;

   // State registers
   always @(posedge clock)
   begin
      if (srst)
      begin
         gate_prev_q  <= 1'b0;
         toggle_q     <= 1'b0;
         stage_prev_q <= 1'b0;
         window_q     <= 1'b0;
      end
      else
      begin
         gate_prev_q  <= gate_in;
         toggle_q     <= toggle_d;
         stage_prev_q <= stage;
         window_q     <= window_d;
      end
   end

endmodule

// ===== design/counter_gate_control.v
// Gate control of a 16-bit counter: source, polarity, toggle, single pulse, status
//
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
`include "gate_control_regs.vh"
module counter_gate_control (
   // Clock and reset
   input  wire                   clock,
   input  wire                   srst,
   // Register port
   input  wire [`GC_ADDR_W-1:0]  addr,
   input  wire [`GC_DATA_W-1:0]  wdata,
   input  wire                   wstrobe,
   input  wire                   rstrobe,
   output reg  [`GC_DATA_W-1:0]  rdata,
   // Gate sources
   input  wire                   gate_pin,
   input  wire                   period_match,
   input  wire                   comparator_one_out,
   input  wire                   comparator_two_out,
   // Counter side
   input  wire                   count_tick,
   output reg                    count_enable,
   output reg                    gate_current_value,
   // Interrupt
   output reg                    irq
);

   // Control fields of gate_control
   reg                   gate_enable_bit_q;
   reg                   gate_polarity_q;
   reg                   gate_toggle_mode_q;
   reg                   gate_single_pulse_mode_q;
   reg                   pulse_acquire_go_q;
   reg                   pulse_acquire_go_d;
   reg  [1:0]            gate_source_select_q;
   // Fields of counter_ctrl
   reg                   counter_on_q;
   reg                   comp_sync_q;
   // Interrupt registers
   reg  [`GC_IRQ_W-1:0]  irq_status_q;
   reg  [`GC_IRQ_W-1:0]  irq_status_d;
   reg  [`GC_IRQ_W-1:0]  irq_enable_q;
   reg  [`GC_IRQ_W-1:0]  irq_events;
   // Gate path
   wire                  pin_sync;
   wire                  comp_one_sync;
   wire                  comp_two_sync;
   wire                  comp_one_sel;
   wire                  comp_two_sel;
   reg                   gate_raw;
   wire                  gate_active;
   wire                  gate_processed;
   wire                  acquire_done;
   wire                  gate_fall;
   // Bus decode
   wire                  wr_gate_control;
   wire                  wr_counter_ctrl;
   wire                  wr_irq_clear;
   wire                  wr_irq_enable;
   reg  [`GC_DATA_W-1:0] read_mux;

   // Reset images; each control field loads its own bits of these on reset
   localparam [`GC_DATA_W-1:0] gate_control_rst = `GC_RST_GATE_CONTROL;
   localparam [1:0]            counter_ctrl_rst = `GC_RST_COUNTER_CTRL;

   // Gate control register image as software reads it
   function [`GC_DATA_W-1:0] gate_control_image;
      input       ge;
      input       pol;
      input       tm;
      input       spm;
      input       go;
      input       val;
      input [1:0] ss;
      begin
         gate_control_image = {ge, pol, tm, spm, go, val, ss};
      end
   endfunction

   // Offset match shared by every write decode
   function is_offset;
      input [`GC_ADDR_W-1:0] a;
      input [`GC_ADDR_W-1:0] off;
      begin
         is_offset = (a == off);
      end
   endfunction

   // Period match comes from logic on this clock, so it needs no synchroniser
   // Gate pin always passes two flops before any edge logic
   gate_sync u_pin_sync (
      .clock     (clock),
      .srst      (srst),
      .level_in  (gate_pin),
      .level_out (pin_sync)
   );

   // Comparator outputs get their own synchronisers
   gate_sync u_comp_one_sync (
      .clock     (clock),
      .srst      (srst),
      .level_in  (comparator_one_out),
      .level_out (comp_one_sync)
   );

   gate_sync u_comp_two_sync (
      .clock     (clock),
      .srst      (srst),
      .level_in  (comparator_two_out),
      .level_out (comp_two_sync)
   );

   // Raw comparator path saves two cycles but is only safe for clean sources
   assign comp_one_sel = comp_sync_q ? comp_one_sync : comparator_one_out;
   assign comp_two_sel = comp_sync_q ? comp_two_sync : comparator_two_out;

   // Gate source selection
   always @*
   begin
      case (gate_source_select_q)
         `GC_SRC_PIN:          gate_raw = pin_sync;
         `GC_SRC_PERIOD_MATCH: gate_raw = period_match;
         `GC_SRC_COMP_ONE:     gate_raw = comp_one_sel;
         `GC_SRC_COMP_TWO:     gate_raw = comp_two_sel;
         default:              gate_raw = pin_sync;
      endcase
   end

   // Polarity: the active level always reaches the next stage as a one
   assign gate_active = gate_polarity_q ? gate_raw : ~gate_raw;

   // Toggle and single-pulse processing
   // Changing polarity with toggling on can fake a rising edge and flip the flop;
   // software should set polarity first and enable toggling in a later write
   gate_pulse u_gate_pulse (
      .clock             (clock),
      .srst              (srst),
      .gate_in           (gate_active),
      .toggle_mode       (gate_toggle_mode_q),
      .single_pulse_mode (gate_single_pulse_mode_q),
      .counter_on        (counter_on_q),
      .acquire_go        (pulse_acquire_go_q),
      .gate_out          (gate_processed),
      .acquire_done      (acquire_done)
   );

   // Write decode
   assign wr_gate_control = wstrobe & is_offset(addr, `GC_OFF_GATE_CONTROL);
   assign wr_counter_ctrl = wstrobe & is_offset(addr, `GC_OFF_COUNTER_CTRL);
   assign wr_irq_clear    = wstrobe & is_offset(addr, `GC_OFF_IRQ_CLEAR);
   assign wr_irq_enable   = wstrobe & is_offset(addr, `GC_OFF_IRQ_ENABLE);

   // Go bit: software arm beats a completion in the same cycle, since it is a new request
   // Single-pulse mode cleared, by this write or from before, cancels any armed acquisition
   always @*
   begin
      pulse_acquire_go_d = pulse_acquire_go_q;
      if (acquire_done)
         pulse_acquire_go_d = 1'b0;
      if (wr_gate_control)
         pulse_acquire_go_d = wdata[`GC_BIT_ACQUIRE_GO];
      if (wr_gate_control && !wdata[`GC_BIT_SINGLE_PULSE])
         pulse_acquire_go_d = 1'b0;
      else if (!wr_gate_control && !gate_single_pulse_mode_q)
         pulse_acquire_go_d = 1'b0;
   end

   // Gate control and counter control registers
   always @(posedge clock)
   begin
      if (srst)
      begin
         gate_enable_bit_q        <= gate_control_rst[`GC_BIT_GATE_ENABLE];
         gate_polarity_q          <= gate_control_rst[`GC_BIT_GATE_POLARITY];
         gate_toggle_mode_q       <= gate_control_rst[`GC_BIT_TOGGLE_MODE];
         gate_single_pulse_mode_q <= gate_control_rst[`GC_BIT_SINGLE_PULSE];
         pulse_acquire_go_q       <= gate_control_rst[`GC_BIT_ACQUIRE_GO];
         gate_source_select_q     <= gate_control_rst[`GC_BIT_SOURCE_HI:`GC_BIT_SOURCE_LO];
         counter_on_q             <= counter_ctrl_rst[`GC_BIT_COUNTER_ON];
         comp_sync_q              <= counter_ctrl_rst[`GC_BIT_COMP_SYNC];
      end
      else
      begin
         pulse_acquire_go_q <= pulse_acquire_go_d;
         if (wr_gate_control)
         begin
            gate_enable_bit_q        <= wdata[`GC_BIT_GATE_ENABLE];
            gate_polarity_q          <= wdata[`GC_BIT_GATE_POLARITY];
            gate_toggle_mode_q       <= wdata[`GC_BIT_TOGGLE_MODE];
            gate_single_pulse_mode_q <= wdata[`GC_BIT_SINGLE_PULSE];
            gate_source_select_q     <= wdata[`GC_BIT_SOURCE_HI:`GC_BIT_SOURCE_LO];
         end
         if (wr_counter_ctrl)
         begin
            counter_on_q <= wdata[`GC_BIT_COUNTER_ON];
            comp_sync_q  <= wdata[`GC_BIT_COMP_SYNC];
         end
      end
   end

   // Falling edge of the reported gate level, independent of gating enable
   assign gate_fall = gate_current_value & ~gate_processed;

   // Sticky status: an event in the clearing cycle survives the clear
   always @*
   begin
      irq_events = {`GC_IRQ_W{1'b0}};
      irq_events[`GC_IRQ_GATE_EVENT] = gate_fall;
      irq_events[`GC_IRQ_ACQ_DONE]   = acquire_done;
      irq_status_d = irq_status_q;
      if (wr_irq_clear)
         irq_status_d = irq_status_q & ~wdata[`GC_IRQ_W-1:0];
      irq_status_d = irq_status_d | irq_events;
   end

   // Interrupt registers and level interrupt
   // An enable written this cycle already counts, so irq follows the new mask at once
   always @(posedge clock)
   begin
      if (srst)
      begin
         irq_status_q <= `GC_RST_IRQ;
         irq_enable_q <= `GC_RST_IRQ;
         irq          <= 1'b0;
      end
      else
      begin
         irq_status_q <= irq_status_d;
         if (wr_irq_enable)
            irq_enable_q <= wdata[`GC_IRQ_W-1:0];
         irq <= |(irq_status_d & (wr_irq_enable ? wdata[`GC_IRQ_W-1:0] : irq_enable_q));
      end
   end

   // Gate value and count qualification, both registered for clean outputs
   // Resetting the gate value to zero makes the first read after reset predictable
   always @(posedge clock)
   begin
      if (srst)
      begin
         gate_current_value <= 1'b0;
         count_enable       <= 1'b0;
      end
      else
      begin
         gate_current_value <= gate_processed;
         if (!counter_on_q)
            count_enable <= 1'b0;
         else if (gate_enable_bit_q)
            count_enable <= count_tick & gate_processed;
         else
            count_enable <= count_tick;
      end
   end

   // Read mux; unmapped and write-only offsets read as zero
   always @*
   begin
      case (addr)
         `GC_OFF_GATE_CONTROL:
            read_mux = gate_control_image(gate_enable_bit_q, gate_polarity_q, gate_toggle_mode_q,
                                          gate_single_pulse_mode_q, pulse_acquire_go_q,
                                          gate_current_value, gate_source_select_q);
         `GC_OFF_COUNTER_CTRL:
            read_mux = {6'h00, comp_sync_q, counter_on_q};
         `GC_OFF_IRQ_STATUS:
            read_mux = {6'h00, irq_status_q};
         `GC_OFF_IRQ_ENABLE:
            read_mux = {6'h00, irq_enable_q};
         default:
            read_mux = 8'h00;
      endcase
   end

   // Read data stand for exactly one cycle after the strobe
   always @(posedge clock)
   begin
      if (srst)
         rdata <= 8'h00;
      else if (rstrobe)
         rdata <= read_mux;
      else
         rdata <= 8'h00;
   end

endmodule

// ===== test/gate_control_monitor.sv
// Port-level assertions for the counter gate control block
`timescale 1ns/100ps
`include "gate_control_regs.vh"
module gate_control_monitor (
   // Clock and reset
   input wire                  clock,
   input wire                  srst,
   // Register port
   input wire [`GC_ADDR_W-1:0] addr,
   input wire [`GC_DATA_W-1:0] wdata,
   input wire                  wstrobe,
   input wire                  rstrobe,
   input wire [`GC_DATA_W-1:0] rdata,
   // Gate sources
   input wire                  gate_pin,
   input wire                  period_match,
   input wire                  comparator_one_out,
   input wire                  comparator_two_out,
   // Counter side and interrupt
   input wire                  count_tick,
   input wire                  count_enable,
   input wire                  gate_current_value,
   input wire                  irq
);
   reg  [3:0] src_q;
   reg  [2:0] quiet_q;
   wire [3:0] src_now;

   assign src_now = {gate_pin, period_match, comparator_one_out, comparator_two_out};

   // Quiet time of all sources; a write restarts it since it reshapes the gate path
   always @(posedge clock)
   begin
      src_q <= src_now;
      if (srst || wstrobe || (src_q != src_now))
         quiet_q <= 3'h0;
      else if (quiet_q != 3'h7)
         quiet_q <= quiet_q + 3'h1;
   end

   property p_reset_clear;
      @(posedge clock) disable iff (srst)
      $past(srst) |-> (rdata == 8'h00) && !count_enable && !gate_current_value && !irq;
   endproperty
   a_reset_clear: assert property (p_reset_clear)
      else $error("outputs not cleared after reset");

   property p_read_idle;
      @(posedge clock) disable iff (srst)
      !$past(rstrobe) |-> rdata == 8'h00;
   endproperty
   a_read_idle: assert property (p_read_idle)
      else $error("read data outside read cycle");

   property p_unmapped_zero;
      @(posedge clock) disable iff (srst)
      $past(rstrobe) && (($past(addr) == 3'h3) || ($past(addr) > 3'h4)) |-> rdata == 8'h00;
   endproperty
   a_unmapped_zero: assert property (p_unmapped_zero)
      else $error("unmapped read not zero");

   property p_value_readback;
      @(posedge clock) disable iff (srst)
      $past(rstrobe) && ($past(addr) == `GC_OFF_GATE_CONTROL) |-> rdata[2] == $past(gate_current_value);
   endproperty
   a_value_readback: assert property (p_value_readback)
      else $error("gate value bit differs from port");

   property p_status_upper;
      @(posedge clock) disable iff (srst)
      $past(rstrobe) && ($past(addr) == `GC_OFF_IRQ_STATUS) |-> rdata[7:2] == 6'h00;
   endproperty
   a_status_upper: assert property (p_status_upper)
      else $error("status upper bits set");

   property p_count_cause;
      @(posedge clock) disable iff (srst)
      count_enable |-> $past(count_tick);
   endproperty
   a_count_cause: assert property (p_count_cause)
      else $error("count enable without tick");

   property p_irq_hold;
      @(posedge clock) disable iff (srst)
      irq && !wstrobe && !$past(wstrobe) |=> irq;
   endproperty
   a_irq_hold: assert property (p_irq_hold)
      else $error("irq dropped without a write");

   property p_value_quiet;
      @(posedge clock) disable iff (srst)
      (quiet_q == 3'h7) |-> $stable(gate_current_value);
   endproperty
   a_value_quiet: assert property (p_value_quiet)
      else $error("gate value moved with quiet sources");
endmodule

bind counter_gate_control gate_control_monitor i_gate_control_monitor (
   .clock(clock), .srst(srst), .addr(addr), .wdata(wdata), .wstrobe(wstrobe),
   .rstrobe(rstrobe), .rdata(rdata), .gate_pin(gate_pin), .period_match(period_match),
   .comparator_one_out(comparator_one_out), .comparator_two_out(comparator_two_out),
   .count_tick(count_tick), .count_enable(count_enable),
   .gate_current_value(gate_current_value), .irq(irq));

// ===== test/gate_source_model.sv
// Far-side model driving the four gate source levels
`timescale 1ns/100ps
module gate_source_model (
   // Clock
   input  wire       clock,
   // Commanded levels: pin, period match, comparator one, comparator two
   input  wire [3:0] level_cmd,
   // Source levels
   output reg        gate_pin,
   output reg        period_match,
   output reg        comparator_one_out,
   output reg        comparator_two_out
);
   // Sources start low so no edge is seen at time zero
   initial {gate_pin, period_match, comparator_one_out, comparator_two_out} = 4'h0;

   // Levels move one cycle after the command, off any design sampling hazard
   always @(posedge clock)
   begin
      {gate_pin, period_match, comparator_one_out, comparator_two_out} <= level_cmd;
   end
endmodule

// ===== test/counter_gate_control_tb.sv
// Self-checking bench of the counter gate control block
`timescale 1ns/100ps
`include "gate_control_regs.vh"
module counter_gate_control_tb;
   reg         clock, srst, wstrobe, rstrobe, count_tick;
   reg  [2:0]  addr;
   reg  [7:0]  wdata, d;
   reg  [3:0]  src;
   reg  [14:0] rows [0:9];
   wire [7:0]  rdata;
   wire        gate_pin, period_match, comp_one, comp_two;
   wire        count_enable, gate_current_value, irq;
   integer     errors, tests_run, i;

   counter_gate_control i_counter_gate_control (
      .clock(clock), .srst(srst), .addr(addr), .wdata(wdata), .wstrobe(wstrobe),
      .rstrobe(rstrobe), .rdata(rdata), .gate_pin(gate_pin), .period_match(period_match),
      .comparator_one_out(comp_one), .comparator_two_out(comp_two), .count_tick(count_tick),
      .count_enable(count_enable), .gate_current_value(gate_current_value), .irq(irq));

   gate_source_model i_gate_source_model (
      .clock(clock), .level_cmd(src), .gate_pin(gate_pin), .period_match(period_match),
      .comparator_one_out(comp_one), .comparator_two_out(comp_two));

   // 20 MHz clock
   initial
   begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   task check(input string name, input [7:0] seen, input [7:0] exp);
   begin
      tests_run = tests_run + 1;
      if (seen !== exp)
      begin
         errors = errors + 1;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   end
   endtask

   task finish_test;
   begin
      $display("checks %0d errors %0d", tests_run, errors);
      if ((errors == 0) && (tests_run > 0))
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   end
   endtask

   task idle(input integer n);
      repeat (n) @(posedge clock);
   endtask

   // One-cycle write strobe, taken at the following edge
   task wr(input [2:0] a, input [7:0] v);
   begin
      @(posedge clock);
      addr <= a;
      wdata <= v;
      wstrobe <= 1'b1;
      @(posedge clock);
      wstrobe <= 1'b0;
   end
   endtask

   // Read data stands only in the cycle after the taken edge
   task rd(input [2:0] a);
   begin
      @(posedge clock);
      addr <= a;
      rstrobe <= 1'b1;
      @(posedge clock);
      rstrobe <= 1'b0;
      #1 d = rdata;
   end
   endtask

   task tick(input exp);
   begin
      @(posedge clock);
      count_tick <= 1'b1;
      @(posedge clock);
      count_tick <= 1'b0;
      #1 check("count_enable", {7'h00, count_enable}, {7'h00, exp});
   end
   endtask

   task expect_value(input exp);
   begin
      idle(8);
      rd(`GC_OFF_GATE_CONTROL);
      check("gate_value", {7'h00, d[2]}, {7'h00, exp});
      check("gate_value_port", {7'h00, gate_current_value}, {7'h00, exp});
   end
   endtask

   task pin_pulse;
   begin
      src <= 4'h8;
      idle(8);
      src <= 4'h0;
      idle(8);
   end
   endtask

   // Watchdog far beyond the expected run length
   initial
   begin
      idle(20000);
      errors = errors + 1;
      finish_test;
   end

   initial
   begin
      {wstrobe, rstrobe, count_tick, addr, wdata, src} = 18'h00000;
      errors = 0;
      tests_run = 0;
      srst = 1'b1;
      // Rows: gate_control, counter_on, sources {pin,match,c1,c2}, gate value, count enable
      rows[0] = {8'hc0, 1'h1, 4'h8, 1'h1, 1'h1};
      rows[1] = {8'hc0, 1'h1, 4'h0, 1'h0, 1'h0};
      rows[2] = {8'h80, 1'h1, 4'h0, 1'h1, 1'h1};
      rows[3] = {8'h40, 1'h1, 4'h0, 1'h0, 1'h1};
      rows[4] = {8'hc1, 1'h1, 4'h4, 1'h1, 1'h1};
      rows[5] = {8'hc2, 1'h1, 4'h2, 1'h1, 1'h1};
      rows[6] = {8'hc2, 1'h1, 4'h1, 1'h0, 1'h0};
      rows[7] = {8'hc3, 1'h1, 4'h1, 1'h1, 1'h1};
      rows[8] = {8'hc3, 1'h1, 4'h2, 1'h0, 1'h0};
      rows[9] = {8'h40, 1'h0, 4'h8, 1'h1, 1'h0};
      idle(8);
      srst <= 1'b0;
      // Every offset reads zero after reset but the live gate value: low-active gate, idle pin
      for (i = 0; i < 8; i = i + 1)
      begin
         rd(i[2:0]);
         check("reset_value", d, (i == 0) ? 8'h04 : 8'h00);
      end
      for (i = 0; i < 10; i = i + 1)
      begin
         wr(`GC_OFF_COUNTER_CTRL, {7'h00, rows[i][6]});
         wr(`GC_OFF_GATE_CONTROL, rows[i][14:7]);
         src <= rows[i][5:2];
         expect_value(rows[i][1]);
         tick(rows[i][0]);
      end
      // Toggle flop: one rise opens, next rise closes; clearing mode or counter resets it
      src <= 4'h0;
      wr(`GC_OFF_COUNTER_CTRL, 8'h01);
      wr(`GC_OFF_GATE_CONTROL, 8'he0);
      pin_pulse;
      expect_value(1'b1);
      pin_pulse;
      expect_value(1'b0);
      pin_pulse;
      wr(`GC_OFF_GATE_CONTROL, 8'hc0);
      wr(`GC_OFF_GATE_CONTROL, 8'he0);
      expect_value(1'b0);
      pin_pulse;
      wr(`GC_OFF_COUNTER_CTRL, 8'h00);
      wr(`GC_OFF_COUNTER_CTRL, 8'h01);
      expect_value(1'b0);
      // Single pulse: armed, one window, then closed until re-armed
      wr(`GC_OFF_IRQ_CLEAR, 8'h03);
      wr(`GC_OFF_GATE_CONTROL, 8'hd8);
      rd(`GC_OFF_GATE_CONTROL);
      check("go_armed", {7'h00, d[3]}, 8'h01);
      src <= 4'h8;
      idle(8);
      tick(1'b1);
      src <= 4'h0;
      idle(8);
      rd(`GC_OFF_GATE_CONTROL);
      check("go_done", {7'h00, d[3]}, 8'h00);
      rd(`GC_OFF_IRQ_STATUS);
      check("status", d, 8'h03);
      src <= 4'h8;
      idle(8);
      tick(1'b0);
      src <= 4'h0;
      wr(`GC_OFF_GATE_CONTROL, 8'hd8);
      wr(`GC_OFF_GATE_CONTROL, 8'hc8);
      rd(`GC_OFF_GATE_CONTROL);
      check("go_cancel", {7'h00, d[3]}, 8'h00);
      // Toggle with single pulse spans a full input period
      wr(`GC_OFF_GATE_CONTROL, 8'hf8);
      pin_pulse;
      expect_value(1'b1);
      pin_pulse;
      rd(`GC_OFF_GATE_CONTROL);
      check("full_period", {6'h00, d[3:2]}, 8'h00);
      // Gate event with gating off: raise, clear, then mask
      wr(`GC_OFF_GATE_CONTROL, 8'h40);
      wr(`GC_OFF_IRQ_CLEAR, 8'h03);
      wr(`GC_OFF_IRQ_ENABLE, 8'h01);
      src <= 4'h8;
      idle(8);
      check("irq_rise", {7'h00, irq}, 8'h00);
      src <= 4'h0;
      idle(8);
      check("irq_fall", {7'h00, irq}, 8'h01);
      wr(`GC_OFF_IRQ_CLEAR, 8'h01);
      idle(2);
      check("irq_clear", {7'h00, irq}, 8'h00);
      wr(`GC_OFF_IRQ_ENABLE, 8'h00);
      pin_pulse;
      check("irq_mask", {7'h00, irq}, 8'h00);
      rd(`GC_OFF_IRQ_STATUS);
      check("status_mask", d, 8'h01);
      // Synchronised comparator path lags the raw one by two cycles
      src <= 4'h0;
      wr(`GC_OFF_COUNTER_CTRL, 8'h03);
      wr(`GC_OFF_GATE_CONTROL, 8'h42);
      rd(`GC_OFF_COUNTER_CTRL);
      check("comp_sync", d, 8'h03);
      @(posedge clock);
      src <= 4'h2;
      idle(2);
      #1 check("sync_early", {7'h00, gate_current_value}, 8'h00);
      idle(2);
      #1 check("sync_late", {7'h00, gate_current_value}, 8'h01);
      src <= 4'h0;
      wr(`GC_OFF_COUNTER_CTRL, 8'h01);
      @(posedge clock);
      src <= 4'h2;
      idle(2);
      #1 check("raw_path", {7'h00, gate_current_value}, 8'h01);
      // Mid-run reset returns every register to zero; only the live gate value reads back set
      @(posedge clock);
      srst <= 1'b1;
      src <= 4'h0;
      idle(2);
      srst <= 1'b0;
      rd(`GC_OFF_GATE_CONTROL);
      check("rerun_gate", d, 8'h04);
      rd(`GC_OFF_COUNTER_CTRL);
      check("rerun_ctrl", d, 8'h00);
      rd(`GC_OFF_IRQ_ENABLE);
      check("rerun_enable", d, 8'h00);
      finish_test;
   end
endmodule
